// >>> verif/pfs_top_tb.sv
// self-checking bench for pfs_top: buffer enables, mode selects, stop exit, reset
// assumes oe follows a write by two edges and a pin reaches its alternate output in three
`timescale 1ns/1ps
`default_nettype none

module pfs_top_tb;
  import pfs_pkg::*;
  typedef struct packed {logic [3:0] addr; logic [3:0] wdata; logic [3:0] exp_oe_n;} pfs_row_type;
  logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, stop_exit_i = 1'b0;
  logic [3:0] addr_i = 4'h0, wdata_i = 4'h0, rd_val;
  logic [D_PINS-1:0] d_pin_i = '0;
  logic [4*R_PORTS-1:0] r_pin_i = '0;
  logic [3:0] rdata_o;
  logic [D_PINS-1:0] d_oe_n_o;
  logic [4*R_PORTS-1:0] r_oe_n_o;
  logic ext_irq_zero_o, ext_irq_one_o, ext_irq_two_o, ext_irq_three_o, ext_irq_four_o;
  logic stop_clear_input_o, event_counter_b_input_o, event_counter_d_input_o;
  int errors = 0, num_checks = 0;
  wire [43:0] oe_all = {r_oe_n_o, d_oe_n_o};
  wire [7:0] alt_vec = {ext_irq_zero_o, ext_irq_one_o, ext_irq_two_o, ext_irq_three_o,
    ext_irq_four_o, stop_clear_input_o, event_counter_b_input_o, event_counter_d_input_o};
  // rows touch D groups and R ports at both ends of the index range
  pfs_row_type rows [8] = '{'{4'h0, 4'h1, 4'he}, '{4'h1, 4'h2, 4'hd}, '{4'h2, 4'h8, 4'h7},
    '{4'h3, 4'hf, 4'h0}, '{4'h4, 4'h5, 4'ha}, '{4'h5, 4'ha, 4'h5}, '{4'h9, 4'h3, 4'hc},
    '{4'ha, 4'hc, 4'h3}};

  pfs_top i_pfs_top (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .stop_exit_i(stop_exit_i), .d_pin_i(d_pin_i),
    .r_pin_i(r_pin_i), .rdata_o(rdata_o), .d_oe_n_o(d_oe_n_o), .r_oe_n_o(r_oe_n_o),
    .ext_irq_zero_o(ext_irq_zero_o), .ext_irq_one_o(ext_irq_one_o),
    .ext_irq_two_o(ext_irq_two_o), .ext_irq_three_o(ext_irq_three_o),
    .ext_irq_four_o(ext_irq_four_o), .stop_clear_input_o(stop_clear_input_o),
    .event_counter_b_input_o(event_counter_b_input_o),
    .event_counter_d_input_o(event_counter_d_input_o));

  initial begin
    forever #2 clk_i = ~clk_i;
  end

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic check(input logic [43:0] seen, input logic [43:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [3:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe, so sample just after that edge
  task automatic rd(input logic [3:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 rd_val = rdata_o;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic test_done;
    $display("checks %0d, mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    settle(20000);
    errors++;
    test_done;
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    settle(1);
    check(oe_all, {44{1'b1}});
    check(alt_vec, 8'hc0);
    $display("reset test done");
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wdata);
      settle(1);
      check(oe_all[4*rows[i].addr +: 4], rows[i].exp_oe_n);
    end
    $display("table test done");
    d_pin_i <= 12'h405;
    r_pin_i <= 32'h0000_018e;
    settle(4);
    check(alt_vec, 8'hc0);
    wr(ADDR_PORT_MODE_C, 4'hf);
    wr(ADDR_PORT_MODE_B, 4'hf);
    settle(4);
    check(alt_vec, 8'h3f);
    check({d_oe_n_o[11:10], r_oe_n_o[8:7], r_oe_n_o[3:0]}, 8'hff);
    $display("mode select test done");
    rd(ADDR_PORT_MODE_C);
    check(rd_val, 4'h0);
    rd(ADDR_PORT_MODE_B);
    check(rd_val, 4'h0);
    rd(4'he);
    check(rd_val, 4'h0);
    rd(ADDR_STATUS);
    check(rd_val, 4'h5);
    settle(1);
    check(rdata_o, 4'h0);
    $display("read test done");
    @(posedge clk_i);
    stop_exit_i <= 1'b1;
    @(posedge clk_i);
    stop_exit_i <= 1'b0;
    settle(3);
    check(alt_vec, 8'hc4);
    $display("stop exit test done");
    @(posedge clk_i);
    ce_i <= 1'b0;
    wr(ADDR_D_BUF0, 4'hf);
    @(posedge clk_i);
    ce_i <= 1'b1;
    settle(1);
    check(d_oe_n_o[3:0], 4'he);
    wr(ADDR_D_BUF0, 4'hf);
    wr(ADDR_D_BUF1, 4'hf);
    wr(ADDR_D_BUF2, 4'hf);
    settle(1);
    check(d_oe_n_o, 12'h400);
    $display("clock enable test done");
    @(posedge clk_i);
    rst_i <= 1'b1;
    settle(2);
    rst_i <= 1'b0;
    settle(1);
    check(oe_all, {44{1'b1}});
    check(alt_vec, 8'hc0);
    $display("second reset test done");
    test_done;
  end
endmodule // pfs_top_tb

`default_nettype wire

// >>> verilog/pfs_pkg.sv
// package for the port output buffer and pin function select block
// assumes a single system clock domain and a plain register port
package pfs_pkg;

  // ------------------------------------------------------------
  // register indices on the plain register port
  // ------------------------------------------------------------
  localparam logic [3:0] ADDR_D_BUF0 = 4'h0;
  localparam logic [3:0] ADDR_D_BUF1 = 4'h1;
  localparam logic [3:0] ADDR_D_BUF2 = 4'h2;
  localparam logic [3:0] ADDR_R_BUF0 = 4'h3;
  localparam logic [3:0] ADDR_PORT_MODE_C = 4'hb;
  localparam logic [3:0] ADDR_PORT_MODE_B = 4'hc;
  localparam logic [3:0] ADDR_STATUS = 4'hd;

  // ------------------------------------------------------------
  // sizes, fields, reset values
  // ------------------------------------------------------------
  localparam int D_PINS = 12;
  localparam int D_GROUPS = 3;
  localparam int R_PORTS = 8;
  localparam logic [3:0] NIBBLE_RESET = 4'h0;
  localparam int PMC_EVN_B = 0;
  localparam int PMC_EVN_D = 1;
  localparam int PMC_STOP_CLEAR_INPUT = 2;
  localparam int PMC_IRQ0 = 3;
  localparam int PMB_IRQ1 = 0;
  localparam int PMB_IRQ2 = 1;
  localparam int PMB_IRQ3 = 2;
  localparam int PMB_IRQ4 = 3;
  // pins that carry an alternate input, as bit indices of the pin vectors
  localparam int D_PIN_STOP_CLEAR_INPUT = 10;
  localparam int D_PIN_IRQ0 = 11;
  localparam int R_PIN_EVN_B = 7;
  localparam int R_PIN_EVN_D = 8;

endpackage : pfs_pkg

// >>> verilog/pfs_top.sv
// buffer enables and pin function selects for the general ports
// assumes register strobes come from logic on clk_i; stop_exit_i is a pulse from clk_i logic
//
// Function
// - each buffer control bit maps to one pin; D groups ascending, R port bit n to pin n
// - mode C bit 3 selects D11 general or active-low external interrupt zero
// - mode C bit 2 selects D10 or stop clear; keeps value on stop exit
// - mode C bit 0 selects event counter B on R1_3, bit 1 counter D on R2_0
// - mode B bit 3 selects R0_3 general or external interrupt four
// - mode B bit 2 selects R0_2 general or external interrupt three
// - mode B bit 1 selects interrupt two on R0_1, bit 0 interrupt one on R0_0
`timescale 1ns/1ps
`default_nettype none

module pfs_top
  import pfs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [3:0] addr_i,
  input wire logic [3:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic stop_exit_i,
  input wire logic [D_PINS-1:0] d_pin_i,
  input wire logic [4*R_PORTS-1:0] r_pin_i,
  output logic [3:0] rdata_o,
  output logic [D_PINS-1:0] d_oe_n_o,
  output logic [4*R_PORTS-1:0] r_oe_n_o,
  output logic ext_irq_zero_o,
  output logic ext_irq_one_o,
  output logic ext_irq_two_o,
  output logic ext_irq_three_o,
  output logic ext_irq_four_o,
  output logic stop_clear_input_o,
  output logic event_counter_b_input_o,
  output logic event_counter_d_input_o
);

  // ------------------------------------------------------------
  // buffer control registers
  // ------------------------------------------------------------
  logic [D_PINS-1:0] d_port_buffer_ctrl_reg;
  logic [4*R_PORTS-1:0] r_port_buffer_ctrl_reg;
  logic [3:0] port_mode_c_reg;
  logic [3:0] port_mode_b_reg;
  logic [D_PINS-1:0] d_sync1_reg, d_sync2_reg;
  logic [4*R_PORTS-1:0] r_sync1_reg, r_sync2_reg;

  genvar g;
  generate
    for (g = 0; g < D_GROUPS; g++) begin : gen_d_grp
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          d_port_buffer_ctrl_reg[4*g +: 4] <= NIBBLE_RESET;
        end else if (ce_i && wr_i && addr_i == ADDR_D_BUF0 + 4'(g)) begin
          d_port_buffer_ctrl_reg[4*g +: 4] <= wdata_i;
        end
      end
    end
    for (g = 0; g < R_PORTS; g++) begin : gen_r_port
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          r_port_buffer_ctrl_reg[4*g +: 4] <= NIBBLE_RESET;
        end else if (ce_i && wr_i && addr_i == ADDR_R_BUF0 + 4'(g)) begin
          r_port_buffer_ctrl_reg[4*g +: 4] <= wdata_i;
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // port mode registers
  // ------------------------------------------------------------
  // stop exit clears every mode bit except the stop clear select; a write to a mode register in the same cycle wins
  // keeping that select armed lets the same pin end the next stop mode
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      port_mode_c_reg <= NIBBLE_RESET;
    end else if (ce_i) begin
      if (wr_i && addr_i == ADDR_PORT_MODE_C) begin
        port_mode_c_reg <= wdata_i;
      end else if (stop_exit_i) begin
        port_mode_c_reg <= port_mode_c_reg & (4'h1 << PMC_STOP_CLEAR_INPUT);
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      port_mode_b_reg <= NIBBLE_RESET;
    end else if (ce_i) begin
      if (wr_i && addr_i == ADDR_PORT_MODE_B) begin
        port_mode_b_reg <= wdata_i;
      end else if (stop_exit_i) begin
        port_mode_b_reg <= NIBBLE_RESET;
      end
    end
  end

  // ------------------------------------------------------------
  // pin sampling, outputs
  // ------------------------------------------------------------
  // two flops per pin: the pins are asynchronous, so the first flop may settle late
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      d_sync1_reg <= '0;
      d_sync2_reg <= '0;
      r_sync1_reg <= '0;
      r_sync2_reg <= '0;
    end else if (ce_i) begin
      d_sync1_reg <= d_pin_i;
      d_sync2_reg <= d_sync1_reg;
      r_sync1_reg <= r_pin_i;
      r_sync2_reg <= r_sync1_reg;
    end
  end

  // a pin given to an alternate input never drives, whatever its buffer bit says
  // enables lag the registers by one edge so every output comes from a flop
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      d_oe_n_o <= '1;
      r_oe_n_o <= '1;
    end else if (ce_i) begin
      d_oe_n_o <= ~d_port_buffer_ctrl_reg;
      d_oe_n_o[D_PIN_IRQ0] <= ~d_port_buffer_ctrl_reg[D_PIN_IRQ0] | port_mode_c_reg[PMC_IRQ0];
      d_oe_n_o[D_PIN_STOP_CLEAR_INPUT] <= ~d_port_buffer_ctrl_reg[D_PIN_STOP_CLEAR_INPUT] | port_mode_c_reg[PMC_STOP_CLEAR_INPUT];
      r_oe_n_o <= ~r_port_buffer_ctrl_reg;
      r_oe_n_o[3:0] <= ~r_port_buffer_ctrl_reg[3:0] | port_mode_b_reg;
      r_oe_n_o[R_PIN_EVN_B] <= ~r_port_buffer_ctrl_reg[R_PIN_EVN_B] | port_mode_c_reg[PMC_EVN_B];
      r_oe_n_o[R_PIN_EVN_D] <= ~r_port_buffer_ctrl_reg[R_PIN_EVN_D] | port_mode_c_reg[PMC_EVN_D];
    end
  end

  // deselected alternate inputs idle inactive: interrupts 0 and 1 high, others low
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ext_irq_zero_o <= 1'b1;
      ext_irq_one_o <= 1'b1;
      ext_irq_two_o <= 1'b0;
      ext_irq_three_o <= 1'b0;
      ext_irq_four_o <= 1'b0;
      stop_clear_input_o <= 1'b0;
      event_counter_b_input_o <= 1'b0;
      event_counter_d_input_o <= 1'b0;
    end else if (ce_i) begin
      ext_irq_zero_o <= port_mode_c_reg[PMC_IRQ0] ? d_sync2_reg[D_PIN_IRQ0] : 1'b1;
      stop_clear_input_o <= port_mode_c_reg[PMC_STOP_CLEAR_INPUT] & d_sync2_reg[D_PIN_STOP_CLEAR_INPUT];
      event_counter_b_input_o <= port_mode_c_reg[PMC_EVN_B] & r_sync2_reg[R_PIN_EVN_B];
      event_counter_d_input_o <= port_mode_c_reg[PMC_EVN_D] & r_sync2_reg[R_PIN_EVN_D];
      ext_irq_four_o <= port_mode_b_reg[PMB_IRQ4] & r_sync2_reg[3];
      ext_irq_three_o <= port_mode_b_reg[PMB_IRQ3] & r_sync2_reg[2];
      ext_irq_two_o <= port_mode_b_reg[PMB_IRQ2] & r_sync2_reg[1];
      ext_irq_one_o <= port_mode_b_reg[PMB_IRQ1] ? r_sync2_reg[0] : 1'b1;
    end
  end

  // mode registers are write-only, so only status reads return the synchronised pin levels of port D low nibble
  // nothing else is readable: software keeps its own copy of what it wrote
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= NIBBLE_RESET;
    end else if (ce_i) begin
      rdata_o <= (rd_i && addr_i == ADDR_STATUS) ? d_sync2_reg[3:0] : NIBBLE_RESET;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_stop_keep: assert property (ce_i && stop_exit_i && !wr_i |=>
    port_mode_c_reg == ($past(port_mode_c_reg) & (4'h1 << PMC_STOP_CLEAR_INPUT)))
    else $error("stop exit mishandled mode c");
  chk_mode_c_wr: assert property (ce_i && wr_i && addr_i == ADDR_PORT_MODE_C |=>
    port_mode_c_reg == $past(wdata_i)) else $error("mode c write lost");
  chk_mode_b_wr: assert property (ce_i && wr_i && addr_i == ADDR_PORT_MODE_B |=>
    port_mode_b_reg == $past(wdata_i)) else $error("mode b write lost");
  chk_d_buf_oe: assert property (ce_i && !port_mode_c_reg[PMC_STOP_CLEAR_INPUT] |=>
    d_oe_n_o[10] == !$past(d_port_buffer_ctrl_reg[10])) else $error("d10 enable wrong");
  chk_r_buf_oe: assert property (ce_i |=>
    r_oe_n_o[31] == !$past(r_port_buffer_ctrl_reg[31])) else $error("r7_3 enable wrong");
  chk_irq_four: assert property (ce_i |=>
    ext_irq_four_o == ($past(port_mode_b_reg[3]) & $past(r_sync2_reg[3])))
    else $error("irq four select wrong");
  chk_irq_three: assert property (ce_i && !port_mode_b_reg[PMB_IRQ3] |=>
    !ext_irq_three_o) else $error("irq three leaked");
  chk_irq_one: assert property (ce_i && !port_mode_b_reg[PMB_IRQ1] |=>
    ext_irq_one_o) else $error("irq one not idle high");
  chk_evn_b: assert property (ce_i && port_mode_c_reg[PMC_EVN_B] |=>
    r_oe_n_o[7]) else $error("r1_3 driven in counter mode");
  chk_irq_zero: assert property (ce_i && port_mode_c_reg[PMC_IRQ0] |=>
    ext_irq_zero_o == $past(d_sync2_reg[D_PIN_IRQ0])) else $error("irq zero path wrong");
  chk_evn_d: assert property (ce_i |=>
    event_counter_d_input_o ==
    ($past(port_mode_c_reg[PMC_EVN_D]) & $past(r_sync2_reg[R_PIN_EVN_D])))
    else $error("counter d select wrong");
  chk_stop_clear_input_idle: assert property (ce_i && !port_mode_c_reg[PMC_STOP_CLEAR_INPUT] |=>
    !stop_clear_input_o) else $error("stop clear leaked");
  chk_rdata_idle: assert property (ce_i && !rd_i |=>
    rdata_o == NIBBLE_RESET) else $error("read data outside read cycle");
  // a frozen cycle must leave both mode registers and all enables where they were
  chk_ce_freeze: assert property (!ce_i |=>
    $stable(port_mode_c_reg) && $stable(port_mode_b_reg) && $stable(d_oe_n_o) &&
    $stable(r_oe_n_o)) else $error("state moved while clock enable low");

  // ------------------------------------------------------------
  // cover points
  // ------------------------------------------------------------
  cov_stop_exit: cover property (stop_exit_i && port_mode_c_reg[PMC_STOP_CLEAR_INPUT]);
  cov_ce_low_wr: cover property (!ce_i && wr_i);
  cov_all_irq: cover property (port_mode_b_reg == 4'hf);
  cov_drive_d: cover property (d_port_buffer_ctrl_reg == 12'hfff);

endmodule // pfs_top

`default_nettype wire
